// ==== logic/cpc_defs.svh ====
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH

// =====================================================================
// register indices (word addresses on the plain register port)
`define CPC_REG_CONFIG0     4'h0
`define CPC_REG_PORT_LIMIT  4'h1
`define CPC_REG_EMERG       4'h2
`define CPC_REG_FEATURES    4'h3
`define CPC_REG_CTRL        4'h4
`define CPC_REG_SIZE_SET    4'h5
`define CPC_REG_CMD         4'h6
`define CPC_REG_STATUS      4'h7
`define CPC_REG_PORT_STATE  4'h8
`define CPC_REG_RX_MSG      4'h9
`define CPC_REG_RX_VALUE    4'ha

// =====================================================================
// feature bit positions
`define CPC_FEAT_SIZE       0
`define CPC_FEAT_MULTIPORT  1
`define CPC_FEAT_EMERG      2

// ctrl register bit positions
`define CPC_CTRL_LEGACY     0
`define CPC_CTRL_BIG_END    1

// =====================================================================
// control event codes
`define CPC_EV_DEVICE_READY 16'h0000
`define CPC_EV_PORT_ADD     16'h0001
`define CPC_EV_PORT_REMOVE  16'h0002
`define CPC_EV_PORT_READY   16'h0003
`define CPC_EV_CONSOLE      16'h0004
`define CPC_EV_RESIZE       16'h0005
`define CPC_EV_PORT_OPEN    16'h0006
`define CPC_EV_PORT_NAME    16'h0007

// =====================================================================
// sizes and reset values
`define CPC_NPORTS          32
`define CPC_PORT_LIMIT_RST  32'h0000_0020
`define CPC_FEAT_OFFER_RST  3'h7
`define CPC_COLS_RST        16'h0050
`define CPC_ROWS_RST        16'h0018
`define CPC_MSG_BYTES       4'h8
`define CPC_RESIZE_BYTES    4'hc

`endif

// ==== logic/cpc_pkg.sv ====
package cpc_pkg;

	// one 8-byte control message, fields held in host order
	typedef struct packed {
		logic [31:0] port_id;
		logic [15:0] event_code;
		logic [15:0] value;
	} cpc_msg_s;

	typedef enum logic [1:0] {
		CPC_TX_IDLE,
		CPC_TX_HDR,
		CPC_TX_EXTRA
	} cpc_tx_e;

	typedef logic [7:0] cpc_byte_t;

endpackage

// ==== logic/cpc_console_port_control.sv ====
`timescale 1ns/1ps
`include "cpc_defs.svh"

// Overview of operation
// - port 0 queues always; others need multiport
// - feature bits: size, multiport, emergency write
// - config: cols, rows, port limit, emergency
// - legacy mode uses guest native byte order
// - emergency write accepted at any time
// - emergency low byte sent out as character
// - size update raises config change; port 0
// - message: port32, event16, value16
// - device sends on rx queue, receives tx
// - events 1 add, 2 remove, value unused
// - event 4 marks console port, several allowed
// - event 5 resize, followed by cols rows
// - event 6 port open state either way
// - event 7 name follows, no terminator; only the 8-byte header is sent
// - never add existing or out-of-limit port
// - never remove a port not added
module cpc_console_port_control
	import cpc_pkg::*;
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	// register port
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	// negotiated features from the transport
	input  wire logic [2:0]  FEAT_ACCEPTED,
	input  wire logic        FEAT_VALID,
	// control receive queue (device to driver), byte stream
	output logic      [7:0]  CRX_DATA,
	output logic             CRX_VALID,
	output logic             CRX_LAST,
	input  wire logic        CRX_READY,
	// control transmit queue (driver to device), one message a beat
	input  wire logic [63:0] CTX_MSG,
	input  wire logic        CTX_VALID,
	output logic             CTX_READY,
	// emergency character output and config change
	output logic      [7:0]  EMERG_CHAR,
	output logic             EMERG_STB,
	output logic             CFG_CHANGE,
	// queue presence
	output logic             CTRL_QUEUES_EN,
	output logic             EXTRA_PORTS_EN
);

	// =================================================================
	// registers
	logic [15:0]         cols_r;
	logic [15:0]         rows_r;
	logic [2:0]          feat_neg_r;
	logic [1:0]          ctrl_r;
	logic                drv_ready_r;
	logic                drv_fail_r;
	logic                cmd_err_r;
	logic                discard_r;
	logic [31:0]         exists_r;
	logic [31:0]         ready_r;
	logic [31:0]         open_r;
	cpc_msg_s            last_rx_r;
	cpc_tx_e             tx_st_r;
	cpc_msg_s            tx_msg_r;
	logic [3:0]          tx_idx_r;
	logic [3:0]          tx_len_r;
	logic [31:0]         tx_extra_r;
	logic [31:0]         rd_r;
	logic [7:0]          emerg_r;
	logic                emerg_stb_r;
	logic                cfg_chg_r;

	logic                multiport;
	logic                legacy_be;
	logic                cmd_go;
	logic                cmd_ok;
	logic [4:0]          cmd_port;
	logic [15:0]         cmd_ev;
	logic                tx_busy;
	cpc_msg_s            rx_msg;
	logic                rx_known;
	logic [4:0]          rx_port;
	logic                rx_take;
	logic [95:0]         tx_bytes;

	assign multiport      = feat_neg_r[`CPC_FEAT_MULTIPORT];
	assign CTRL_QUEUES_EN = multiport;
	assign EXTRA_PORTS_EN = multiport;
	// byte swap applies only to a big-endian guest on the legacy interface
	assign legacy_be      = ctrl_r[`CPC_CTRL_LEGACY] & ctrl_r[`CPC_CTRL_BIG_END];

	// =================================================================
	// byte order helpers
	function automatic logic [15:0] ord16(input logic [15:0] v, input logic be);
		ord16 = be ? {v[7:0], v[15:8]} : v;
	endfunction

	function automatic logic [31:0] ord32(input logic [31:0] v, input logic be);
		ord32 = be ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
	endfunction

	// =================================================================
	// feature negotiation: only offered bits can be accepted
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			feat_neg_r <= 3'h0;
		end else if (FEAT_VALID) begin
			feat_neg_r <= FEAT_ACCEPTED & `CPC_FEAT_OFFER_RST;
		end
	end

	// control register (legacy mode, guest endianness)
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_r <= 2'h0;
		end else if (REG_WR && REG_ADDR == `CPC_REG_CTRL) begin
			ctrl_r <= REG_WDATA[1:0];
		end
	end

	// =================================================================
	// console size; a change notifies only when size is negotiated
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cols_r    <= `CPC_COLS_RST;
			rows_r    <= `CPC_ROWS_RST;
			cfg_chg_r <= 1'b0;
		end else begin
			cfg_chg_r <= 1'b0;
			if (REG_WR && REG_ADDR == `CPC_REG_SIZE_SET) begin
				cols_r    <= REG_WDATA[15:0];
				rows_r    <= REG_WDATA[31:16];
				cfg_chg_r <= feat_neg_r[`CPC_FEAT_SIZE];
			end
		end
	end
	assign CFG_CHANGE = cfg_chg_r;

	// =================================================================
	// emergency write: no gating on negotiation or queue state at all
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			emerg_r     <= 8'h00;
			emerg_stb_r <= 1'b0;
		end else begin
			emerg_stb_r <= 1'b0;
			if (REG_WR && REG_ADDR == `CPC_REG_EMERG) begin
				emerg_r     <= legacy_be ? REG_WDATA[31:24] : REG_WDATA[7:0];
				emerg_stb_r <= 1'b1;
			end
		end
	end
	assign EMERG_CHAR = emerg_r;
	assign EMERG_STB  = emerg_stb_r;

	// =================================================================
	// command from software: {extra[31:16]? no: port[4:0], event}
	// CMD word: [2:0] event, [12:8] port, [15] value; extra from SIZE
	assign cmd_go   = REG_WR && REG_ADDR == `CPC_REG_CMD;
	assign cmd_port = REG_WDATA[12:8];
	assign cmd_ev   = {13'h0000, REG_WDATA[2:0]};
	assign tx_busy  = tx_st_r != CPC_TX_IDLE;

	// legality of a device-originated message
	always_comb begin
		cmd_ok = multiport && drv_ready_r && !tx_busy;
		case (cmd_ev)
			`CPC_EV_PORT_ADD:    cmd_ok = cmd_ok && !exists_r[cmd_port];
			`CPC_EV_PORT_REMOVE: cmd_ok = cmd_ok && exists_r[cmd_port];
			`CPC_EV_CONSOLE,
			`CPC_EV_RESIZE,
			`CPC_EV_PORT_OPEN,
			`CPC_EV_PORT_NAME:   cmd_ok = cmd_ok && exists_r[cmd_port];
			default:             cmd_ok = 1'b0;
		endcase
	end

	// serialise header plus optional trailer onto the control receive queue
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tx_st_r    <= CPC_TX_IDLE;
			tx_msg_r   <= '0;
			tx_idx_r   <= 4'h0;
			tx_len_r   <= 4'h0;
			tx_extra_r <= 32'h0;
		end else begin
			case (tx_st_r)
				CPC_TX_IDLE: begin
					if (cmd_go && cmd_ok) begin
						tx_msg_r.port_id    <= {27'h0, cmd_port};
						tx_msg_r.event_code <= cmd_ev;
						tx_msg_r.value      <= {15'h0, REG_WDATA[15]};
						// resize appends cols and rows; a name event sends the header alone
						tx_extra_r <= {rows_r, cols_r};
						tx_len_r   <= (cmd_ev == `CPC_EV_RESIZE) ?
							`CPC_RESIZE_BYTES : `CPC_MSG_BYTES;
						tx_idx_r   <= 4'h0;
						tx_st_r    <= CPC_TX_HDR;
					end
				end
				CPC_TX_HDR: begin
					if (CRX_READY) begin
						tx_idx_r <= tx_idx_r + 4'h1;
						if (tx_idx_r == tx_len_r - 4'h1) begin
							tx_st_r <= CPC_TX_IDLE;
						end
					end
				end
				default: tx_st_r <= CPC_TX_IDLE;
			endcase
		end
	end

	// little-endian wire image, swapped field by field for a legacy big-endian guest
	assign tx_bytes = {
		ord16(tx_extra_r[31:16], legacy_be), ord16(tx_extra_r[15:0], legacy_be),
		ord16(tx_msg_r.value, legacy_be), ord16(tx_msg_r.event_code, legacy_be),
		ord32(tx_msg_r.port_id, legacy_be)};
	assign CRX_VALID = tx_st_r == CPC_TX_HDR;
	assign CRX_DATA  = tx_bytes[{tx_idx_r[3:0], 3'b000} +: 8];
	assign CRX_LAST  = CRX_VALID && (tx_idx_r == tx_len_r - 4'h1);

	// =================================================================
	// driver-to-device messages; accepted in one cycle once multiport is negotiated
	assign CTX_READY          = multiport;
	assign rx_take            = CTX_VALID && CTX_READY;
	assign rx_msg.port_id     = ord32(CTX_MSG[31:0], legacy_be);
	assign rx_msg.event_code  = ord16(CTX_MSG[47:32], legacy_be);
	assign rx_msg.value       = ord16(CTX_MSG[63:48], legacy_be);
	assign rx_port            = rx_msg.port_id[4:0];
	// ready ignores the port number; port ready and open must name a created port, other events are discarded
	always_comb begin
		case (rx_msg.event_code)
			`CPC_EV_DEVICE_READY: rx_known = 1'b1;
			`CPC_EV_PORT_READY,
			`CPC_EV_PORT_OPEN:    rx_known = rx_msg.port_id < `CPC_PORT_LIMIT_RST
				&& exists_r[rx_port];
			default:              rx_known = 1'b0;
		endcase
	end

	// port state; device add/remove and driver replies
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			exists_r    <= 32'h0;
			ready_r     <= 32'h0;
			open_r      <= 32'h0;
			drv_ready_r <= 1'b0;
			drv_fail_r  <= 1'b0;
			discard_r   <= 1'b0;
			cmd_err_r   <= 1'b0;
			last_rx_r   <= '0;
		end else begin
			if (cmd_go) begin
				cmd_err_r <= !cmd_ok;
			end
			if (cmd_go && cmd_ok) begin
				case (cmd_ev)
					`CPC_EV_PORT_ADD: exists_r[cmd_port] <= 1'b1;
					`CPC_EV_PORT_REMOVE: begin
						exists_r[cmd_port] <= 1'b0;
						ready_r[cmd_port]  <= 1'b0;
						open_r[cmd_port]   <= 1'b0;
					end
					default: ;
				endcase
			end
			if (rx_take) begin
				last_rx_r <= rx_msg;
				if (!rx_known) begin
					discard_r <= 1'b1;
				end else begin
					case (rx_msg.event_code)
						`CPC_EV_DEVICE_READY: begin
							drv_ready_r <= rx_msg.value == 16'h0001;
							drv_fail_r  <= rx_msg.value != 16'h0001;
						end
						`CPC_EV_PORT_READY: ready_r[rx_port] <= rx_msg.value == 16'h0001;
						`CPC_EV_PORT_OPEN:  open_r[rx_port] <= rx_msg.value[0];
						default: ;
					endcase
				end
			end else if (REG_RD && REG_ADDR == `CPC_REG_STATUS) begin
				// read clears the discard flag unless a message is taken in the same cycle
				discard_r <= 1'b0;
			end
		end
	end

	// =================================================================
	// register read, data valid the cycle after the strobe
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_r <= 32'h0;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`CPC_REG_CONFIG0:    rd_r <= {ord16(rows_r, legacy_be),
					ord16(cols_r, legacy_be)};
				`CPC_REG_PORT_LIMIT: rd_r <= ord32(`CPC_PORT_LIMIT_RST, legacy_be);
				`CPC_REG_FEATURES:   rd_r <= {13'h0, feat_neg_r, 13'h0, `CPC_FEAT_OFFER_RST};
				`CPC_REG_CTRL:       rd_r <= {30'h0, ctrl_r};
				`CPC_REG_SIZE_SET:   rd_r <= {rows_r, cols_r};
				`CPC_REG_STATUS:     rd_r <= {26'h0, cmd_err_r, discard_r, drv_fail_r,
					drv_ready_r, tx_busy, multiport};
				`CPC_REG_PORT_STATE: rd_r <= exists_r;
				`CPC_REG_RX_MSG:     rd_r <= last_rx_r.port_id;
				`CPC_REG_RX_VALUE:   rd_r <= {last_rx_r.value, last_rx_r.event_code};
				default:             rd_r <= 32'h0; // emergency field is write-only
			endcase
		end else begin
			rd_r <= 32'h0;
		end
	end
	assign REG_RDATA = rd_r;

endmodule

// ==== verif/cpc_asserts.sv ====
`timescale 1ns/1ps
`include "cpc_defs.svh"

// =====================================================================
// port checks on the console control block
module cpc_asserts (
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	// register port
	input wire logic [3:0]  REG_ADDR,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	// control queues
	input wire logic [7:0]  CRX_DATA,
	input wire logic        CRX_VALID,
	input wire logic        CRX_LAST,
	input wire logic        CRX_READY,
	input wire logic        CTX_READY,
	// side outputs
	input wire logic        EMERG_STB,
	input wire logic        CFG_CHANGE,
	input wire logic        CTRL_QUEUES_EN,
	input wire logic        EXTRA_PORTS_EN
);
	logic [3:0] nbyte_r;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);

	// bytes taken so far in the current message
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			nbyte_r <= 4'h0;
		else if (CRX_VALID && CRX_READY)
			nbyte_r <= CRX_LAST ? 4'h0 : nbyte_r + 4'h1;
	end

	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside answer cycle");
	a_limit_read: assert property (REG_RD && REG_ADDR == `CPC_REG_PORT_LIMIT
		|=> REG_RDATA == `CPC_PORT_LIMIT_RST) else $error("port limit read wrong");
	a_emerg_wo: assert property (REG_RD && REG_ADDR == `CPC_REG_EMERG
		|=> REG_RDATA == 32'h0) else $error("emergency field readable");
	a_emerg_pulse: assert property (REG_WR && REG_ADDR == `CPC_REG_EMERG
		|=> EMERG_STB) else $error("emergency write lost");
	a_emerg_cause: assert property (EMERG_STB
		|-> $past(REG_WR && REG_ADDR == `CPC_REG_EMERG)) else $error("stray character");
	a_cfg_cause: assert property (CFG_CHANGE
		|-> $past(REG_WR && REG_ADDR == `CPC_REG_SIZE_SET)) else $error("stray change");
	a_queue_gate: assert property (CTX_READY == CTRL_QUEUES_EN
		&& EXTRA_PORTS_EN == CTRL_QUEUES_EN) else $error("queue enables disagree");
	a_crx_gate: assert property (CRX_VALID |-> CTRL_QUEUES_EN)
		else $error("control sent without multiport");
	a_crx_hold: assert property (CRX_VALID && !CRX_READY
		|=> CRX_VALID && $stable(CRX_DATA) && $stable(CRX_LAST)) else $error("byte not held");
	a_msg_len: assert property (CRX_VALID && CRX_LAST
		|-> nbyte_r == 4'h7 || nbyte_r == 4'hb) else $error("message length wrong");
endmodule

bind cpc_console_port_control cpc_asserts u_asserts (
	.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CRX_DATA(CRX_DATA), .CRX_VALID(CRX_VALID),
	.CRX_LAST(CRX_LAST), .CRX_READY(CRX_READY), .CTX_READY(CTX_READY),
	.EMERG_STB(EMERG_STB), .CFG_CHANGE(CFG_CHANGE), .CTRL_QUEUES_EN(CTRL_QUEUES_EN),
	.EXTRA_PORTS_EN(EXTRA_PORTS_EN)
);

// ==== verif/cpc_guest_model.sv ====
`timescale 1ns/1ps

// =====================================================================
// guest driver stand-in on the control queues
module cpc_guest_model (
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	// control receive queue
	input wire logic [7:0]  CRX_DATA,
	input wire logic        CRX_VALID,
	input wire logic        CRX_LAST,
	output logic            CRX_READY,
	// control transmit queue
	output logic     [63:0] CTX_MSG,
	output logic            CTX_VALID,
	input wire logic        CTX_READY,
	input wire logic        CTRL_QUEUES_EN
);
	logic [63:0] tx_q[$];
	logic [99:0] rx_q[$];
	logic [95:0] acc = 96'h0;
	int          n = 0;

	initial begin
		CRX_READY = 1'b0;
		CTX_VALID = 1'b0;
		CTX_MSG = 64'h0;
	end

	// readiness as soon as the control queues come up
	always @(posedge CTRL_QUEUES_EN)
		tx_q.push_back(64'h0001_0000_0000_0000);

	// random stalls so the device must hold each byte
	always @(posedge REF_CLK)
		CRX_READY <= ($urandom_range(3) != 0);

	// gather bytes into a device-written buffer; answer add and console
	always @(posedge REF_CLK) begin
		if (RST_B && CRX_VALID && CRX_READY) begin
			acc[8*n +: 8] = CRX_DATA;
			n = n + 1;
			if (CRX_LAST) begin
				rx_q.push_back({4'(n), acc});
				if (acc[47:32] == 16'h0001)
					tx_q.push_back({16'h0001, 16'h0003, acc[31:0]});
				if (acc[47:32] == 16'h0004)
					tx_q.push_back({16'h0001, 16'h0006, acc[31:0]});
				acc = 96'h0;
				n = 0;
			end
		end
	end

	// one whole message a beat, held until taken, then the bus is scrambled
	always begin
		@(posedge REF_CLK);
		if (tx_q.size() != 0) begin
			CTX_MSG <= tx_q[0];
			CTX_VALID <= 1'b1;
			do
				@(posedge REF_CLK);
			while (CTX_READY !== 1'b1);
			CTX_VALID <= 1'b0;
			CTX_MSG <= ~tx_q.pop_front();
		end
	end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`include "cpc_defs.svh"

// =====================================================================
// console control bench
module testbench;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [2:0]  feat_acc = 3'h0;
	logic        feat_valid = 1'b0;
	wire  [31:0] reg_rdata;
	wire  [7:0]  crx_data, emerg_char;
	wire  [63:0] ctx_msg;
	wire         crx_valid, crx_last, crx_ready, ctx_valid, ctx_ready;
	wire         emerg_stb, cfg_change, ctrl_en, xp_en;
	logic [63:0] rd_q[$];
	logic [7:0]  ch_q[$];
	logic [99:0] msg_q[$];
	logic [63:0] t;
	logic [31:0] d;
	logic [15:0] cols, rows;
	logic [4:0]  p;
	logic        rd_f = 1'b0;
	int          fails = 0, check_count = 0, cfg_n = 0, cyc = 0;

	always #2.5 ref_clk = ~ref_clk;

	cpc_console_port_control uut (
		.REF_CLK(ref_clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FEAT_ACCEPTED(feat_acc),
		.FEAT_VALID(feat_valid), .CRX_DATA(crx_data), .CRX_VALID(crx_valid),
		.CRX_LAST(crx_last), .CRX_READY(crx_ready), .CTX_MSG(ctx_msg), .CTX_VALID(ctx_valid),
		.CTX_READY(ctx_ready), .EMERG_CHAR(emerg_char), .EMERG_STB(emerg_stb),
		.CFG_CHANGE(cfg_change), .CTRL_QUEUES_EN(ctrl_en), .EXTRA_PORTS_EN(xp_en));

	cpc_guest_model gm (
		.REF_CLK(ref_clk), .RST_B(rst_b), .CRX_DATA(crx_data), .CRX_VALID(crx_valid),
		.CRX_LAST(crx_last), .CRX_READY(crx_ready), .CTX_MSG(ctx_msg), .CTX_VALID(ctx_valid),
		.CTX_READY(ctx_ready), .CTRL_QUEUES_EN(ctrl_en));

	// =================================================================
	// shared tasks
	task automatic chk(input string nm, input logic [99:0] e, input logic [99:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// expected value goes in with a mask of the bits that matter
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		rd_q.push_back({m, e});
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic idle();
		while (msg_q.size() != 0 || gm.tx_q.size() != 0 || ctx_valid !== 1'b0)
			@(posedge ref_clk);
	endtask

	// a refused command must send nothing, so no note is taken for it
	task automatic cmd(input logic [2:0] ev, input logic [4:0] pt, input logic v, input bit ok);
		if (ok)
			msg_q.push_back({(ev == 3'h5) ? {`CPC_RESIZE_BYTES, rows, cols}
				: {`CPC_MSG_BYTES, 32'h0}, {15'h0, v}, {13'h0, ev}, {27'h0, pt}});
		wr(`CPC_REG_CMD, {16'h0, v, 2'b00, pt, 5'h00, ev});
		idle();
	endtask

	// =================================================================
	// watcher: each answer is matched against the oldest note
	always @(negedge ref_clk) begin
		if (rd_f) begin
			t = rd_q.pop_front();
			chk("read data", 100'(t[31:0]), 100'(reg_rdata & t[63:32]));
		end
		if (emerg_stb === 1'b1)
			chk("emergency char", 100'(ch_q.size() ? ch_q.pop_front() : 8'hxx),
				100'(emerg_char));
		if (gm.rx_q.size() != 0)
			chk("control msg", msg_q.size() ? msg_q.pop_front() : 100'hx,
				gm.rx_q.pop_front());
		if (cfg_change === 1'b1)
			cfg_n++;
		rd_f = reg_rd;
	end

	// a hang is cut short well past the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end

	// =================================================================
	// main sequence
	initial begin
		void'($urandom(17528));
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(`CPC_REG_CONFIG0, {`CPC_ROWS_RST, `CPC_COLS_RST}, '1);
		rd(`CPC_REG_PORT_LIMIT, `CPC_PORT_LIMIT_RST, '1);
		rd(`CPC_REG_FEATURES, 32'h7, '1);
		rd(4'hf, 32'h0, '1);
		// characters before any negotiation or queue setup
		repeat (3) begin
			d = $urandom();
			ch_q.push_back(d[7:0]);
			wr(`CPC_REG_EMERG, d);
		end
		rd(`CPC_REG_EMERG, 32'h0, '1);
		cmd(3'h1, 5'h1, 1'b0, 1'b0);
		rd(`CPC_REG_STATUS, 32'h20, 32'h27);
		wr(`CPC_REG_SIZE_SET, 32'h0030_0090);
		chk("queue enables", 100'({ctrl_en, xp_en, ctx_ready}), 100'h0);
		// accept every offered feature; the latch must hold after the strobe
		@(posedge ref_clk);
		feat_acc <= 3'h7;
		feat_valid <= 1'b1;
		@(posedge ref_clk);
		feat_valid <= 1'b0;
		feat_acc <= 3'h0;
		rd(`CPC_REG_FEATURES, 32'h0007_0007, '1);
		idle();
		rd(`CPC_REG_STATUS, 32'h5, 32'hf);
		chk("queue enables", 100'({ctrl_en, xp_en, ctx_ready}), 100'h7);
		d = $urandom();
		cols = d[15:0];
		rows = d[31:16];
		wr(`CPC_REG_SIZE_SET, d);
		rd(`CPC_REG_CONFIG0, d, '1);
		chk("change pulses", 100'(cfg_n), 100'h1);
		// a random port through its whole life
		p = 5'($urandom());
		cmd(3'h1, p, 1'b0, 1'b1);
		rd(`CPC_REG_PORT_STATE, 32'h1 << p, '1);
		cmd(3'h1, p, 1'b0, 1'b0);
		cmd(3'h2, p + 5'h1, 1'b0, 1'b0);
		cmd(3'h4, p, 1'b0, 1'b1);
		rd(`CPC_REG_RX_VALUE, 32'h0001_0006, '1);
		rd(`CPC_REG_RX_MSG, 32'(p), '1);
		cmd(3'h5, p, 1'b0, 1'b1);
		cmd(3'h6, p, 1'b1, 1'b1);
		cmd(3'h7, p, 1'b0, 1'b1);
		// driver faults: unknown event, then a port past the limit
		gm.tx_q.push_back({16'h0001, 16'h0009, 27'h0, p});
		gm.tx_q.push_back({16'h0000, 16'h0006, 32'h0000_0020});
		idle();
		rd(`CPC_REG_STATUS, 32'h10, 32'h10);
		rd(`CPC_REG_STATUS, 32'h0, 32'h10);
		rd(`CPC_REG_PORT_STATE, 32'h1 << p, '1);
		cmd(3'h2, p, 1'b0, 1'b1);
		rd(`CPC_REG_PORT_STATE, 32'h0, '1);
		// legacy guest in big-endian order takes the top byte
		wr(`CPC_REG_CTRL, 32'h3);
		d = $urandom();
		ch_q.push_back(d[31:24]);
		wr(`CPC_REG_EMERG, d);
		repeat (4) @(posedge ref_clk);
		chk("notes left", 100'(rd_q.size() + ch_q.size() + msg_q.size()), 100'h0);
		final_report();
	end
endmodule
